// ==== src/tcm_pkg.sv ====
// Constants shared by the timer compare match unit
package tcm_pkg;

    // =====================================================
    // Widths
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned PIN_N  = 2;

    // =====================================================
    // Register offsets
    localparam logic [2:0] OFS_CTRL   = 3'h0;
    localparam logic [2:0] OFS_CMP_LO = 3'h1;
    localparam logic [2:0] OFS_CMP_HI = 3'h2;
    localparam logic [2:0] OFS_ROUTE  = 3'h3;
    localparam logic [2:0] OFS_STAT   = 3'h4;
    localparam logic [2:0] OFS_MASK   = 3'h5;
    localparam logic [2:0] OFS_STATE  = 3'h6;

    // =====================================================
    // Field positions
    localparam int unsigned MODE_LSB     = 0;
    localparam int unsigned MODE_W       = 4;
    localparam int unsigned FLAG_BIT     = 0;
    localparam int unsigned ROUTE_BIT    = 0;
    localparam int unsigned ST_LATCH_BIT = 0;
    localparam int unsigned ST_PEND_BIT  = 1;
    localparam int unsigned ST_MATCH_BIT = 2;

    // =====================================================
    // Reset values
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_CMP   = 8'h00;
    localparam logic       RST_ROUTE = 1'h0;
    localparam logic       RST_MASK  = 1'h0;
    localparam logic       RST_FLAG  = 1'h0;
    localparam logic       RST_LATCH = 1'h0;
    localparam logic [7:0] RD_ZERO   = 8'h00;

    // =====================================================
    // Compare mode codes
    localparam logic [3:0] MODE_OFF    = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_SET    = 4'h8;
    localparam logic [3:0] MODE_CLEAR  = 4'h9;
    localparam logic [3:0] MODE_SWINT  = 4'hA;
    localparam logic [3:0] MODE_TRIG   = 4'hB;

endpackage

// ==== src/tcm_link_if.sv ====
// Internal link between the compare core, match detector and pin router
`timescale 1ns/10ps
interface tcm_link_if;
    logic [tcm_pkg::CNT_W-1:0] cmp_value;
    logic [tcm_pkg::CNT_W-1:0] timer_count;
    logic                      arm;
    logic                      match_level;
    logic                      match_pulse;
    logic                      pin_value;
    logic                      pin_drive;
    logic                      route_sel;
    logic [tcm_pkg::PIN_N-1:0] pin_out;
    logic [tcm_pkg::PIN_N-1:0] pin_oe;

    // Match detector side
    modport det (
        input  cmp_value, timer_count, arm,
        output match_level, match_pulse
    );

    // Pin router side
    modport rt (
        input  pin_value, pin_drive, route_sel,
        output pin_out, pin_oe
    );
endinterface

// ==== src/tcm_match_detect.sv ====
// Equality detector with first-match pulse
`timescale 1ns/10ps
module tcm_match_detect (
    input  wire logic   clk_sys_in,
    input  wire logic   nrst_in,
    tcm_link_if.det     link
);
    import tcm_pkg::*;

    typedef struct packed {
        logic prev;
    } tcm_det_t;

    tcm_det_t det_reg;
    tcm_det_t det_next;
    logic     equal;

    // =====================================================
    // Compare and edge detect
    assign equal = (link.cmp_value == link.timer_count); // [R1]

    always_comb begin
        det_next      = det_reg;
        det_next.prev = equal;
    end

    // Level is raw, pulse only on the first cycle of equality
    assign link.match_level = equal;
    assign link.match_pulse = equal & ~det_reg.prev & link.arm; // [R16] [R13]

    // State register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            det_reg <= '0;
        end else begin
            det_reg <= det_next;
        end
    end
endmodule // tcm_match_detect

// ==== src/tcm_pin_route.sv ====
// Steers the compare output to one of the pin locations
`timescale 1ns/10ps
module tcm_pin_route (
    tcm_link_if.rt link
);
    import tcm_pkg::*;

    // =====================================================
    // One location per pin, selected by route bit
    for (genvar i = 0; i < PIN_N; i++) begin : g_loc
        logic sel;
        assign sel            = (link.route_sel == 1'(i));
        assign link.pin_oe[i]  = sel & link.pin_drive; // [R14]
        assign link.pin_out[i] = sel & link.pin_drive & link.pin_value;
    end
endmodule // tcm_pin_route

// ==== src/tcm_compare_unit.sv ====
// Timer compare match unit: registers, match actions, trigger, interrupt
//
// Overview of operation
// R1: The 16-bit compare value is checked every cycle against the 16-bit timer count.
// R2: A match performs the one action picked by the mode field: toggle, set, clear, trigger or irq.
// R3: Every compare mode sets the match flag on the same clock as its action.
// R4: Software interrupt mode raises the flag but leaves the pin undriven.
// R5: Trigger mode resets the timer and starts a conversion if enabled, pin undriven.
// R6: The special event output rises in the very cycle the match is seen.
// R7: The timer reset itself waits for the next rising edge of the timer clock.
// R8: The trigger reset never sets the timer overflow flag.
// R9: If the match is gone before that edge, the timer reset is dropped.
// R10: Writing zero to the control register clears the output latch, not the port latch.
// R11: Software makes the pin an output through its direction bit before using compare.
// R12: Software keeps the timer in a synchronous mode while compare is used.
// R13: Without the system clock, in sleep, no match is detected or acted on.
// R14: The compare output can be moved to an alternate pin by the route register.
// R15: Unimplemented register bits read as zero.
// R16: The action and flag fire once when equality first appears, not every cycle.
// R17: Toggle, set and clear use their own distinct codes apart from irq and trigger.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module tcm_compare_unit (
    input  wire logic                         clk_sys_in,
    input  wire logic                         nrst_in,
    input  wire logic [tcm_pkg::ADDR_W-1:0]   reg_addr_in,
    input  wire logic [tcm_pkg::DATA_W-1:0]   reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic      [tcm_pkg::DATA_W-1:0]   reg_rdata_out,
    input  wire logic [tcm_pkg::CNT_W-1:0]    timer_count_in,
    input  wire logic                         timer_tick_in,
    input  wire logic                         sleep_in,
    input  wire logic                         adc_enable_in,
    output logic                              special_event_out,
    output logic                              timer_reset_out,
    output logic                              adc_start_out,
    output logic      [tcm_pkg::PIN_N-1:0]    compare_pin_out,
    output logic      [tcm_pkg::PIN_N-1:0]    compare_pin_oe_out,
    output logic                              irq_out
);
    import tcm_pkg::*;

    // =====================================================
    // State of the unit
    typedef struct packed {
        logic [7:0] module_control;
        logic [7:0] compare_value_low;
        logic [7:0] compare_value_high;
        logic       pin_route_select;
        logic       match_flag;
        logic       match_enable;
        logic       out_latch;
        logic       pend_reset;
        logic [7:0] rdata;
    } tcm_state_t;

    tcm_state_t st_reg;
    tcm_state_t st_next;

    tcm_link_if link ();

    logic [3:0] mode;
    logic       mode_cmp;
    logic       mode_pin;
    logic       act;
    logic       ctrl_zero_wr;
    logic       trig_now;

    // =====================================================
    // Mode decode
    assign mode = st_reg.module_control[MODE_LSB +: MODE_W];

    // Compare modes that take part in matching
    always_comb begin
        mode_cmp = 1'b0;
        mode_pin = 1'b0;
        unique case (mode)
            MODE_TOGGLE,
            MODE_SET,
            MODE_CLEAR: begin // [R17]
                mode_cmp = 1'b1;
                mode_pin = 1'b1;
            end
            MODE_SWINT: begin
                mode_cmp = 1'b1; // [R4]
            end
            MODE_TRIG: begin
                mode_cmp = 1'b1; // [R5]
            end
            default: begin
                mode_cmp = 1'b0;
                mode_pin = 1'b0;
            end
        endcase
    end

    // =====================================================
    // Match detector
    assign link.cmp_value   = {st_reg.compare_value_high,
                               st_reg.compare_value_low}; // [R1]
    assign link.timer_count = timer_count_in;
    assign link.arm         = mode_cmp & ~sleep_in; // [R13]

    tcm_match_detect u_detect (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .link       (link.det)
    );

    // One action per first match
    assign act = link.match_pulse; // [R16]

    // =====================================================
    // Pin router
    assign link.pin_value = st_reg.out_latch;
    assign link.pin_drive = mode_pin; // [R4] [R5]
    assign link.route_sel = st_reg.pin_route_select;

    tcm_pin_route u_route (
        .link (link.rt)
    );

    assign compare_pin_out    = link.pin_out; // [R14]
    assign compare_pin_oe_out = link.pin_oe;

    // =====================================================
    // Trigger outputs
    assign trig_now = act & (mode == MODE_TRIG);

    // Trigger leaves in the match cycle itself
    assign special_event_out = trig_now; // [R6]
    assign adc_start_out     = trig_now & adc_enable_in; // [R5]

    // Reset only on the timer edge, only while still matching
    assign timer_reset_out = timer_tick_in
                           & st_reg.pend_reset
                           & link.match_level
                           & (mode == MODE_TRIG); // [R7] [R9]

    // Reset is a separate strobe, overflow flag untouched
    // [R8]

    // =====================================================
    // Interrupt output
    assign irq_out = st_reg.match_flag & st_reg.match_enable;

    // =====================================================
    // Register bus, match actions
    assign ctrl_zero_wr = reg_wr_in
                        & (reg_addr_in == OFS_CTRL)
                        & (reg_wdata_in == RD_ZERO);

    always_comb begin
        st_next       = st_reg;
        st_next.rdata = RD_ZERO;

        // Software writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_CTRL: begin
                    st_next.module_control = reg_wdata_in;
                end
                OFS_CMP_LO: begin
                    st_next.compare_value_low = reg_wdata_in;
                end
                OFS_CMP_HI: begin
                    st_next.compare_value_high = reg_wdata_in;
                end
                OFS_ROUTE: begin
                    st_next.pin_route_select = reg_wdata_in[ROUTE_BIT]; // [R14]
                end
                OFS_STAT: begin
                    if (reg_wdata_in[FLAG_BIT]) begin
                        st_next.match_flag = 1'b0;
                    end
                end
                OFS_MASK: begin
                    st_next.match_enable = reg_wdata_in[FLAG_BIT];
                end
                default: begin
                    st_next.rdata = RD_ZERO;
                end
            endcase
        end

        // Software reads, data valid next cycle
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_CTRL: begin
                    st_next.rdata = st_reg.module_control;
                end
                OFS_CMP_LO: begin
                    st_next.rdata = st_reg.compare_value_low;
                end
                OFS_CMP_HI: begin
                    st_next.rdata = st_reg.compare_value_high;
                end
                OFS_ROUTE: begin
                    st_next.rdata[ROUTE_BIT] = st_reg.pin_route_select; // [R15]
                end
                OFS_STAT: begin
                    st_next.rdata[FLAG_BIT] = st_reg.match_flag; // [R15]
                end
                OFS_MASK: begin
                    st_next.rdata[FLAG_BIT] = st_reg.match_enable;
                end
                OFS_STATE: begin
                    st_next.rdata[ST_LATCH_BIT] = st_reg.out_latch;
                    st_next.rdata[ST_PEND_BIT]  = st_reg.pend_reset;
                    st_next.rdata[ST_MATCH_BIT] = link.match_level;
                end
                default: begin
                    st_next.rdata = RD_ZERO; // [R15]
                end
            endcase
        end

        // Pending reset ends at the timer edge or when match is lost
        if (timer_tick_in || !link.match_level) begin
            st_next.pend_reset = 1'b0; // [R9]
        end
        if (mode != MODE_TRIG) begin
            st_next.pend_reset = 1'b0;
        end

        // Match action, flag set wins over a software clear
        if (act) begin
            st_next.match_flag = 1'b1; // [R3]
            unique case (mode)
                MODE_TOGGLE: begin
                    st_next.out_latch = ~st_reg.out_latch; // [R2]
                end
                MODE_SET: begin
                    st_next.out_latch = 1'b1; // [R2]
                end
                MODE_CLEAR: begin
                    st_next.out_latch = 1'b0; // [R2]
                end
                MODE_TRIG: begin
                    st_next.pend_reset = 1'b1; // [R5] [R7]
                end
                default: begin
                    st_next.out_latch = st_reg.out_latch; // [R4]
                end
            endcase
        end

        // Clearing the control register drops the latch
        if (ctrl_zero_wr) begin
            st_next.out_latch = RST_LATCH; // [R10]
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg.module_control     <= RST_CTRL;
            st_reg.compare_value_low  <= RST_CMP;
            st_reg.compare_value_high <= RST_CMP;
            st_reg.pin_route_select   <= RST_ROUTE;
            st_reg.match_flag         <= RST_FLAG;
            st_reg.match_enable       <= RST_MASK;
            st_reg.out_latch          <= RST_LATCH;
            st_reg.pend_reset         <= 1'b0;
            st_reg.rdata              <= RD_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    // Read data from flip-flop
    assign reg_rdata_out = st_reg.rdata;

endmodule // tcm_compare_unit

// ==== test/tcm_compare_checker.sv ====
// Port assertions for the timer compare match unit
`timescale 1ns/10ps
module tcm_compare_checker
    import tcm_pkg::*;
(
    input wire logic                        clk_sys_in,
    input wire logic                        nrst_in,
    input wire logic                        reg_rd_in,
    input wire logic [tcm_pkg::DATA_W-1:0]  reg_rdata_out,
    input wire logic                        timer_tick_in,
    input wire logic                        sleep_in,
    input wire logic                        adc_enable_in,
    input wire logic                        special_event_out,
    input wire logic                        timer_reset_out,
    input wire logic                        adc_start_out,
    input wire logic [tcm_pkg::PIN_N-1:0]   compare_pin_oe_out,
    input wire logic                        irq_out
);
    // ==========================================
    // Trigger, reset and bus relations
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    a_adc_start_gate: assert property (adc_start_out == (special_event_out && adc_enable_in))
        else $error("adc start not tied to trigger");
    a_trig_single_pulse: assert property (special_event_out |=> !special_event_out)
        else $error("trigger repeated");
    a_sleep_no_trig: assert property (sleep_in |-> !special_event_out)
        else $error("trigger during sleep");
    a_reset_on_tick: assert property (timer_reset_out |-> timer_tick_in)
        else $error("timer reset without tick");
    a_reset_not_match: assert property (special_event_out |-> !timer_reset_out)
        else $error("timer reset at match");
    a_reset_once: assert property (timer_reset_out |=> !timer_reset_out)
        else $error("timer reset repeated");
    a_route_one_pin: assert property ($onehot0(compare_pin_oe_out))
        else $error("two pin locations driven");
    a_trig_no_pin: assert property (special_event_out |-> compare_pin_oe_out == 2'h0)
        else $error("pin driven in trigger mode");
    a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == RD_ZERO)
        else $error("read data outside read cycle");

    // Main scenarios reached
    c_trig: cover property (special_event_out);
    c_reset: cover property (timer_reset_out);
    c_irq: cover property ($rose(irq_out));
endmodule // tcm_compare_checker

// ==== test/tcm_pin_load.sv ====
// Pull-down load on the compare pin locations
`timescale 1ns/10ps
module tcm_pin_load
    import tcm_pkg::*;
(
    input  wire logic [tcm_pkg::PIN_N-1:0] pin_in,
    input  wire logic [tcm_pkg::PIN_N-1:0] pin_oe_in,
    output logic      [tcm_pkg::PIN_N-1:0] level_out
);
    // ==========================================
    // Undriven locations fall to the pull-down level
    always_comb begin
        for (int i = 0; i < PIN_N; i++) begin
            level_out[i] = pin_oe_in[i] ? pin_in[i] : 1'b0;
        end
    end
endmodule // tcm_pin_load

// ==== test/tb_top.sv ====
// Self-checking bench for the timer compare match unit
`timescale 1ns/10ps
module tb_top;
    import tcm_pkg::*;
    logic              clk_sys_in = 1'b0;
    logic              nrst_in    = 1'b0;
    logic [ADDR_W-1:0] addr       = 3'h0;
    logic [DATA_W-1:0] wdata      = 8'h00;
    logic              wr = 1'b0, rd = 1'b0, tick = 1'b0, slp = 1'b0, adc_en = 1'b0;
    logic [CNT_W-1:0]  cnt        = 16'h0001;
    logic [CNT_W-1:0]  cmp;
    logic [DATA_W-1:0] rdata;
    logic              sev, trst, adcs, irq, lat;
    logic [PIN_N-1:0]  pin, oe, lvl;
    logic [3:0]        m;
    logic [3:0]        modes [4] = '{MODE_TOGGLE, MODE_SET, MODE_CLEAR, MODE_SWINT};
    int                err_count = 0, checked = 0, cyc = 0;

    tcm_compare_unit i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .timer_count_in(cnt), .timer_tick_in(tick), .sleep_in(slp), .adc_enable_in(adc_en),
        .special_event_out(sev), .timer_reset_out(trst), .adc_start_out(adcs),
        .compare_pin_out(pin), .compare_pin_oe_out(oe), .irq_out(irq));
    tcm_pin_load i_load (.pin_in(pin), .pin_oe_in(oe), .level_out(lvl));

    // ==========================================
    // Clock and cycle ceiling
    always #4 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    // Expected latch after a match
    function automatic logic nxt(input logic [3:0] md, input logic l);
        return (md == MODE_TOGGLE) ? ~l : (md == MODE_SET) ? 1'b1 : (md == MODE_CLEAR) ? 1'b0 : l;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 chk("register", {8'h00, exp}, {8'h00, rdata});
    endtask

    // Count steps off and back onto the compare value
    task automatic hit(input logic tk);
        @(posedge clk_sys_in);
        cnt <= cmp ^ 16'h0001;
        @(posedge clk_sys_in);
        cnt <= cmp;
        tick <= tk;
        #1;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h0FBD));
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
        wr_reg(OFS_ROUTE, 8'hFF);
        rd_chk(OFS_ROUTE, 8'h01);
        wr_reg(OFS_ROUTE, 8'h00);
        wr_reg(3'h7, 8'hFF);
        rd_chk(3'h7, 8'h00);
        wr_reg(OFS_CTRL, 8'hF0);
        rd_chk(OFS_CTRL, 8'hF0);
        wr_reg(OFS_MASK, 8'hFF);
        rd_chk(OFS_MASK, 8'h01);
        cmp = 16'($urandom);
        wr_reg(OFS_CMP_LO, cmp[7:0]);
        wr_reg(OFS_CMP_HI, cmp[15:8]);
        rd_chk(OFS_CMP_LO, cmp[7:0]);
        rd_chk(OFS_CMP_HI, cmp[15:8]);
        lat = 1'b0;
        for (int i = 0; i < 12; i++) begin
            // First four passes run set, clear, irq only and toggle once each
            m = (i < 4) ? modes[(i + 1) % 4] : modes[$urandom_range(0, 3)];
            wr_reg(OFS_CTRL, {4'h0, m});
            hit(1'b0);
            lat = nxt(m, lat);
            settle();
            chk("pin level", {15'h0, lat & (m != MODE_SWINT)}, {15'h0, lvl[0]});
            chk("pin enable", {15'h0, m != MODE_SWINT}, {14'h0, oe});
            chk("irq", 16'h0001, {15'h0, irq});
            rd_chk(OFS_STAT, 8'h01);
            rd_chk(OFS_STATE, {5'h0, 1'b1, 1'b0, lat});
            wr_reg(OFS_STAT, 8'h01);
            #1 chk("irq cleared", 16'h0000, {15'h0, irq});
        end
        // Trigger: immediate pulse, reset waits for a later tick
        adc_en <= 1'b1;
        wr_reg(OFS_CTRL, {4'h0, MODE_TRIG});
        hit(1'b1);
        chk("special event", 16'h0001, {15'h0, sev});
        chk("adc start", 16'h0001, {15'h0, adcs});
        chk("early reset", 16'h0000, {15'h0, trst});
        @(posedge clk_sys_in);
        tick <= 1'b0;
        @(posedge clk_sys_in);
        tick <= 1'b1;
        #1 chk("timer reset", 16'h0001, {15'h0, trst});
        chk("trigger pin", 16'h0000, {14'h0, oe});
        @(posedge clk_sys_in);
        tick <= 1'b0;
        adc_en <= 1'b0;
        hit(1'b0);
        chk("adc idle", 16'h0000, {15'h0, adcs});
        wr_reg(OFS_CMP_LO, cmp[7:0] ^ 8'h01);
        @(posedge clk_sys_in);
        tick <= 1'b1;
        #1 chk("dropped reset", 16'h0000, {15'h0, trst});
        @(posedge clk_sys_in);
        tick <= 1'b0;
        wr_reg(OFS_CMP_LO, cmp[7:0]);
        // Zero control write, sleep, route and mask
        wr_reg(OFS_CTRL, {4'h0, MODE_SET});
        hit(1'b0);
        wr_reg(OFS_CTRL, 8'h00);
        rd_chk(OFS_STATE, 8'h04);
        wr_reg(OFS_CTRL, {4'h0, MODE_SET});
        wr_reg(OFS_STAT, 8'h01);
        slp <= 1'b1;
        hit(1'b0);
        settle();
        rd_chk(OFS_STAT, 8'h00);
        chk("sleep pin", 16'h0000, {14'h0, lvl});
        slp <= 1'b0;
        wr_reg(OFS_ROUTE, 8'h01);
        wr_reg(OFS_MASK, 8'h00);
        hit(1'b0);
        settle();
        chk("routed pin", 16'h0002, {14'h0, lvl});
        chk("masked irq", 16'h0000, {15'h0, irq});
        rd_chk(OFS_STAT, 8'h01);
        end_sim();
    end
endmodule // tb_top

bind tcm_compare_unit tcm_compare_checker i_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .timer_tick_in(timer_tick_in),
    .sleep_in(sleep_in), .adc_enable_in(adc_enable_in), .special_event_out(special_event_out),
    .timer_reset_out(timer_reset_out), .adc_start_out(adc_start_out),
    .compare_pin_oe_out(compare_pin_oe_out), .irq_out(irq_out));
